//--- src/adhrs_top.sv
// Drive/head select and status registers of the task file
//
// Notes on behaviour
// R1: Two-drive mode: select bit 4 picks drive
// R2: Single mode select one: unselected, status 00h
// R3: Bit 6 picks CHS or LBA addressing
// R4: Bits 3..0 head, or LBA 27..24
// R5: Head field follows track crossings
// R6: Host should write ones to bits 7, 5
// R7: Status refreshed at completion and on errors
// R8: Busy hides status and blocks other registers
// R9: Status read acknowledges pending interrupt
// R10: Busy set by resets, command; cleared later
// R11: Host leaves registers alone while busy
// R12: Ready needs seek complete; else refuse any command
// R13: Not-ready aborts, sets error, holds ready low
// R14: Ready low until spindle up after power-on
// R15: Fault sets fault, error; held till command
// R16: Seek clears, then sets seek complete; freeze
// R17: Seek complete low until spindle up
// R18: Data request when buffer needs a sector
// R19: Error flags failure, stops multi-sector, cleared
// R20: Reserved status bits 2, 1 read zero
// R21: Start only not busy and ready; clear interrupt
`timescale 1ns/1ps
`default_nettype none
module adhrs_top
    import adhrs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Task-file pins
    input wire logic cs0_n_i,
    input wire logic dior_n_i,
    input wire logic diow_n_i,
    input wire logic [2:0] da_i,
    input wire logic [7:0] dd_i,
    output logic [7:0] dd_o,
    output logic dd_oe_o,
    output logic intrq_o,
    // Reset sources
    input wire logic hardware_reset_line_n_i,
    input wire logic software_reset_bit_i,
    // Configuration
    input wire logic two_drive_cfg_i,
    input wire logic drive_id_i,
    // Drive controller events
    input wire logic spindle_ready_i,
    input wire logic seek_start_i,
    input wire logic seek_done_i,
    input wire logic seek_fail_i,
    input wire logic fault_i,
    input wire logic not_ready_i,
    input wire logic sector_buf_req_i,
    input wire logic cmd_done_i,
    input wire logic cmd_error_i,
    input wire logic track_cross_i,
    input wire logic [HEAD_W-1:0] new_head_i,
    // To the drive controller
    output logic lba_mode_o,
    output logic [HEAD_W-1:0] head_number_field_o,
    output logic drive_select_o,
    output logic selected_o,
    output logic cmd_start_o,
    output logic [7:0] cmd_code_o,
    output logic multi_abort_o
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic hardware_reset_line_s1;
        logic hardware_reset_line_s2;
        logic [7:0] drive_head_select;
        logic sel;
        logic busy_flag;
        logic ready_flag;
        logic fault_flag;
        logic seek_complete_flag;
        logic data_request_flag;
        logic err;
        logic intrq;
        logic active;
        logic spun;
        logic ready_hold;
        logic seek_frz;
        logic abort;
        logic [7:0] dd_out;
        logic dd_oe;
    } adhrs_top_type;

    adhrs_top_type s;
    adhrs_top_type next_s;

    adhrs_bus_if bus ();

    logic cc_start;
    logic cc_refuse;
    logic cc_taken;
    logic [7:0] cc_code;
    logic ready_live;
    logic hardware_reset_line;
    logic stat_rd;
    logic may_drive;
    logic [7:0] status_word;
    logic [7:0] status_read;

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    adhrs_host_port u_port (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .cs0_n_i(cs0_n_i),
        .dior_n_i(dior_n_i),
        .diow_n_i(diow_n_i),
        .da_i(da_i),
        .dd_i(dd_i),
        .bus(bus)
    );

    // Live readiness ignores the hold so the next command can clear it
    assign ready_live = s.spun & s.seek_complete_flag & spindle_ready_i;

    adhrs_cmd_check u_check (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .bus(bus),
        .busy_i(s.busy_flag),
        .sel_i(s.sel),
        .ready_live_i(ready_live),
        .fault_live_i(fault_i),
        .start_o(cc_start),
        .refuse_o(cc_refuse),
        .taken_o(cc_taken),
        .code_o(cc_code)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.hardware_reset_line_s1 = hardware_reset_line_n_i;
        next_s.hardware_reset_line_s2 = s.hardware_reset_line_s1;
        next_s.abort = 1'b0;
        hardware_reset_line = ~s.hardware_reset_line_s2;
        stat_rd = bus.rd_start && bus.rd_addr == ADDR_STATUS && s.sel;

        // Status image; bits 2 and 1 stay zero [R20]
        status_word = '0;
        status_word[ST_BUSY] = s.busy_flag;
        status_word[ST_READY] = s.ready_flag;
        status_word[ST_FAULT] = s.fault_flag;
        status_word[ST_SEEK] = s.seek_complete_flag;
        status_word[ST_DREQ] = s.data_request_flag;
        status_word[ST_ERR] = s.err;
        if (!s.sel) begin
            status_read = STATUS_UNSEL; // [R2]
        end else if (s.busy_flag) begin
            status_read = STATUS_BUSY_ONLY; // [R8]
        end else begin
            status_read = status_word; // [R7]
        end

        // Drive/head register; reserved bits kept as written [R6]
        if (bus.wr_pulse && bus.wr_addr == ADDR_DRIVE_HEAD && !s.busy_flag) begin
            next_s.drive_head_select = bus.wr_data; // [R3] [R4] [R8]
        end
        if (track_cross_i) begin
            next_s.drive_head_select[HEAD_W-1:0] = new_head_i; // [R5]
        end
        if (two_drive_cfg_i) begin
            next_s.sel = next_s.drive_head_select[DH_DRV] == drive_id_i; // [R1]
        end else begin
            next_s.sel = ~next_s.drive_head_select[DH_DRV]; // [R2]
        end

        // Clears first, so a same-cycle set below wins
        if (stat_rd) begin
            next_s.intrq = 1'b0; // [R9]
            next_s.seek_frz = 1'b0; // [R16]
        end
        if (cc_taken) begin
            next_s.intrq = 1'b0; // [R21]
            next_s.err = 1'b0; // [R19]
            next_s.fault_flag = 1'b0; // [R15]
            next_s.ready_hold = 1'b0; // [R13]
        end
        if (cc_start) begin
            next_s.busy_flag = 1'b1; // [R10]
            next_s.active = 1'b1;
        end
        if (cc_refuse) begin
            next_s.err = 1'b1; // [R12]
            next_s.intrq = 1'b1;
        end

        // Spindle up after power-on releases seek complete [R14] [R17]
        if (!s.spun && spindle_ready_i) begin
            next_s.spun = 1'b1;
            next_s.seek_complete_flag = 1'b1;
        end

        // Seek tracking; a failed seek freezes the bit until read [R16]
        if (s.active && !s.seek_frz) begin
            if (seek_start_i) begin
                next_s.seek_complete_flag = 1'b0;
            end
            if (seek_done_i) begin
                next_s.seek_complete_flag = 1'b1;
            end
        end
        if (s.active && seek_fail_i) begin
            next_s.seek_complete_flag = s.seek_complete_flag;
            next_s.seek_frz = 1'b1;
            next_s.err = 1'b1;
            next_s.active = 1'b0;
            next_s.busy_flag = 1'b0;
            next_s.intrq = 1'b1;
        end

        // Error conditions during a command
        if (s.active && cmd_error_i) begin
            next_s.err = 1'b1; // [R19]
        end
        if (s.active && not_ready_i) begin
            next_s.err = 1'b1; // [R13]
            next_s.ready_hold = 1'b1;
            next_s.active = 1'b0;
            next_s.busy_flag = 1'b0;
            next_s.intrq = 1'b1;
        end
        if (s.active && fault_i) begin
            next_s.fault_flag = 1'b1; // [R15]
            next_s.err = 1'b1;
            next_s.active = 1'b0;
            next_s.busy_flag = 1'b0;
            next_s.intrq = 1'b1;
        end

        // Data request clears busy and raises the interrupt [R18] [R10]
        next_s.data_request_flag = sector_buf_req_i & next_s.active &
                                   ~next_s.err;
        if (next_s.data_request_flag && !s.data_request_flag) begin
            next_s.busy_flag = 1'b0;
            next_s.intrq = 1'b1;
        end

        // Completion ends busy; it also ends a reset sequence [R10]
        if (cmd_done_i) begin
            if (s.active || s.busy_flag) begin
                next_s.intrq = 1'b1;
            end
            next_s.busy_flag = 1'b0;
            next_s.active = 1'b0;
            next_s.data_request_flag = 1'b0;
        end

        // Resets hold busy for as long as they are asserted [R10]
        if (hardware_reset_line || software_reset_bit_i) begin
            next_s.busy_flag = 1'b1;
            next_s.active = 1'b0;
            next_s.data_request_flag = 1'b0;
            next_s.intrq = 1'b0;
        end

        // Rising error stops any multi-sector run [R19]
        next_s.abort = next_s.err & ~s.err;

        // Ready needs seek complete and no pending not-ready hold [R12]
        next_s.ready_flag = next_s.spun & next_s.seek_complete_flag &
                            spindle_ready_i & ~next_s.ready_hold; // [R13]

        // Read data is registered: one cycle after the synced strobe
        may_drive = s.sel || !two_drive_cfg_i;
        next_s.dd_oe = 1'b0;
        next_s.dd_out = READ_IDLE;
        if (bus.rd_active && may_drive) begin
            if (bus.rd_addr == ADDR_STATUS) begin
                next_s.dd_oe = 1'b1;
                next_s.dd_out = status_read;
            end else if (bus.rd_addr == ADDR_DRIVE_HEAD) begin
                next_s.dd_oe = 1'b1;
                // Avoids leaking status through another register [R8]
                next_s.dd_out = s.busy_flag ? READ_IDLE : s.drive_head_select;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s <= '{hardware_reset_line_s1: 1'b1, hardware_reset_line_s2: 1'b1,
                   drive_head_select: DH_RESET, sel: 1'b1,
                   busy_flag: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign dd_o = s.dd_out;
    assign dd_oe_o = s.dd_oe;
    assign intrq_o = s.intrq;
    assign lba_mode_o = s.drive_head_select[DH_LBA]; // [R3]
    assign head_number_field_o = s.drive_head_select[HEAD_W-1:0]; // [R4]
    assign drive_select_o = s.drive_head_select[DH_DRV];
    assign selected_o = s.sel;
    assign cmd_start_o = cc_start;
    assign cmd_code_o = cc_code;
    assign multi_abort_o = s.abort;
endmodule
`default_nettype wire

//--- src/adhrs_pkg.sv
// Constants and types shared by the drive/head and status register block
package adhrs_pkg;

    // ------------------------------------------------------------
    // Task-file addresses behind chip select 0
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_DRIVE_HEAD = 3'h6;
    localparam logic [2:0] ADDR_STATUS = 3'h7;

    // ------------------------------------------------------------
    // Drive/head register fields
    // ------------------------------------------------------------
    localparam int unsigned DH_LBA = 6;
    localparam int unsigned DH_DRV = 4;
    localparam int unsigned HEAD_W = 4;
    localparam logic [7:0] DH_RESET = 8'ha0;

    // ------------------------------------------------------------
    // Status register fields and fixed answers
    // ------------------------------------------------------------
    localparam int unsigned ST_BUSY = 7;
    localparam int unsigned ST_READY = 6;
    localparam int unsigned ST_FAULT = 5;
    localparam int unsigned ST_SEEK = 4;
    localparam int unsigned ST_DREQ = 3;
    localparam int unsigned ST_ERR = 0;
    localparam logic [7:0] STATUS_UNSEL = 8'h00;
    localparam logic [7:0] STATUS_BUSY_ONLY = 8'h80;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // ------------------------------------------------------------
    // Command classes that need a ready, fault-free drive
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_GRP_READ = 4'h2;
    localparam logic [3:0] CMD_GRP_WRITE = 4'h3;
    localparam logic [3:0] CMD_GRP_VERIFY = 4'h4;
    localparam logic [3:0] CMD_GRP_SEEK = 4'h7;
    localparam logic [3:0] CMD_GRP_MULTI = 4'hc;

    // Width of the synchronised pin bundle: cs, dior, diow, da, dd
    localparam int unsigned PIN_W = 14;

endpackage

//--- src/adhrs_bus_if.sv
// Carrier for decoded task-file bus events between the block's modules
`timescale 1ns/1ps
`default_nettype none
interface adhrs_bus_if;
    logic rd_active;
    logic rd_start;
    logic [2:0] rd_addr;
    logic wr_pulse;
    logic [2:0] wr_addr;
    logic [7:0] wr_data;
    modport port (
        output rd_active, rd_start, rd_addr, wr_pulse, wr_addr, wr_data
    );
    modport core (
        input rd_active, rd_start, rd_addr, wr_pulse, wr_addr, wr_data
    );
endinterface
`default_nettype wire

//--- src/adhrs_host_port.sv
// Pin synchroniser and strobe decoder for the parallel task-file bus
`timescale 1ns/1ps
`default_nettype none
module adhrs_host_port
    import adhrs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Task-file pins
    input wire logic cs0_n_i,
    input wire logic dior_n_i,
    input wire logic diow_n_i,
    input wire logic [2:0] da_i,
    input wire logic [7:0] dd_i,
    // Decoded events
    adhrs_bus_if.port bus
);
    typedef struct packed {
        logic [PIN_W-1:0] s1;
        logic [PIN_W-1:0] s2;
        logic rd_prev;
        logic wr_prev;
        logic [2:0] wr_addr;
        logic [7:0] wr_data;
    } adhrs_hp_type;

    adhrs_hp_type s;
    adhrs_hp_type next_s;
    logic rd_now;
    logic wr_now;

    // ------------------------------------------------------------
    // Strobe decode on the second stage only
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.s1 = {cs0_n_i, dior_n_i, diow_n_i, da_i, dd_i};
        next_s.s2 = s.s1;
        rd_now = ~s.s2[13] & ~s.s2[12];
        wr_now = ~s.s2[13] & ~s.s2[11];
        next_s.rd_prev = rd_now;
        next_s.wr_prev = wr_now;
        // Data is taken while the strobe is low, so release skew is harmless
        if (wr_now) begin
            next_s.wr_addr = s.s2[10:8];
            next_s.wr_data = s.s2[7:0];
        end
        bus.rd_active = rd_now;
        bus.rd_start = rd_now & ~s.rd_prev;
        bus.rd_addr = s.s2[10:8];
        bus.wr_pulse = s.wr_prev & ~wr_now;
        bus.wr_addr = s.wr_addr;
        bus.wr_data = s.wr_data;
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s <= '{s1: '1, s2: '1, default: '0};
        end else begin
            s <= next_s;
        end
    end
endmodule
`default_nettype wire

//--- src/adhrs_cmd_check.sv
// Command acceptance: takes or refuses a command register write
`timescale 1ns/1ps
`default_nettype none
module adhrs_cmd_check
    import adhrs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Bus events
    adhrs_bus_if.core bus,
    // Drive state
    input wire logic busy_i,
    input wire logic sel_i,
    input wire logic ready_live_i,
    input wire logic fault_live_i,
    // Results
    output logic start_o,
    output logic refuse_o,
    output logic taken_o,
    output logic [7:0] code_o
);
    typedef struct packed {
        logic start;
        logic refuse;
        logic taken;
        logic [7:0] code;
    } adhrs_cc_type;

    adhrs_cc_type s;
    adhrs_cc_type next_s;
    logic media;
    logic [3:0] grp;

    always_comb begin
        next_s = s;
        next_s.start = 1'b0;
        next_s.refuse = 1'b0;
        next_s.taken = 1'b0;
        grp = bus.wr_data[7:4];
        media = (grp == CMD_GRP_READ) || (grp == CMD_GRP_WRITE) ||
                (grp == CMD_GRP_VERIFY) || (grp == CMD_GRP_SEEK) ||
                (grp == CMD_GRP_MULTI);
        // Writes while busy are dropped without trace [R8]
        if (bus.wr_pulse && bus.wr_addr == ADDR_STATUS && !busy_i && sel_i) begin
            next_s.taken = 1'b1;
            next_s.code = bus.wr_data;
            // Needs ready; fault blocks media commands only [R21] [R12] [R15]
            if (!ready_live_i || (media && fault_live_i)) begin
                next_s.refuse = 1'b1;
            end else begin
                next_s.start = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign start_o = s.start;
    assign refuse_o = s.refuse;
    assign taken_o = s.taken;
    assign code_o = s.code;
endmodule
`default_nettype wire

//--- verification/adhrs_top_asserts.sv
// Concurrent checks on the drive/head and status register ports
`timescale 1ns/1ps
`default_nettype none
module adhrs_top_asserts
    import adhrs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Watched ports
    input wire logic diow_n_i,
    input wire logic [2:0] da_i,
    input wire logic [7:0] dd_o,
    input wire logic dd_oe_o,
    input wire logic intrq_o,
    input wire logic hardware_reset_line_n_i,
    input wire logic two_drive_cfg_i,
    input wire logic drive_id_i,
    input wire logic sector_buf_req_i,
    input wire logic drive_select_o,
    input wire logic selected_o,
    input wire logic cmd_start_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    // ------------------------------------------------------------
    // Read answers
    // ------------------------------------------------------------
    property p_busy;
        dd_oe_o && dd_o[ST_BUSY] && $past(da_i, 3) == ADDR_STATUS
            |-> dd_o == STATUS_BUSY_ONLY;
    endproperty
    a_busy: assert property (p_busy) else $error("busy hides bits");
    property p_rsv;
        dd_oe_o && $past(da_i, 3) == ADDR_STATUS |-> dd_o[2:1] == 2'b00;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved set");
    property p_unsel;
        dd_oe_o && !two_drive_cfg_i && drive_select_o
            && $past(da_i, 3) == ADDR_STATUS |-> dd_o == STATUS_UNSEL;
    endproperty
    a_unsel: assert property (p_unsel) else $error("unsel status");
    // Registered flags can lag by one clock, so only settled states count
    property p_sel;
        two_drive_cfg_i && $stable(two_drive_cfg_i) && $stable(drive_select_o)
            |-> selected_o == (drive_select_o == drive_id_i);
    endproperty
    a_sel: assert property (p_sel) else $error("drive select");
    // ------------------------------------------------------------
    // Interrupt and command timing
    // ------------------------------------------------------------
    property p_ack;
        $rose(dd_oe_o) && $past(da_i, 3) == ADDR_STATUS && selected_o
            && !drive_select_o && !sector_buf_req_i |-> !intrq_o;
    endproperty
    a_ack: assert property (p_ack) else $error("status read ack");
    property p_start;
        $rose(cmd_start_o) |-> $past(diow_n_i, 3) && !$past(diow_n_i, 4);
    endproperty
    a_start: assert property (p_start) else $error("start timing");
    property p_clr;
        cmd_start_o |=> !intrq_o && !cmd_start_o;
    endproperty
    a_clr: assert property (p_clr) else $error("start clears");
    property p_hardware_reset_line;
        !hardware_reset_line_n_i [*5] |-> !intrq_o;
    endproperty
    a_hardware_reset_line: assert property (p_hardware_reset_line) else $error("reset line");
endmodule
bind adhrs_top adhrs_top_asserts u_chk (
    .core_clk_i, .arst_n_i, .diow_n_i, .da_i, .dd_o, .dd_oe_o, .intrq_o,
    .hardware_reset_line_n_i, .two_drive_cfg_i, .drive_id_i,
    .sector_buf_req_i, .drive_select_o, .selected_o, .cmd_start_o
);
`default_nettype wire

//--- verification/adhrs_host_model.sv
// Host adapter model driving the parallel task-file pins
`timescale 1ns/1ps
`default_nettype none
module adhrs_host_model
    import adhrs_pkg::*;
(
    // Clock
    input wire logic core_clk_i,
    // Task-file pins
    output logic cs0_n_o,
    output logic dior_n_o,
    output logic diow_n_o,
    output logic [2:0] da_o,
    output logic [7:0] dd_o
);
    initial begin
        cs0_n_o = 1'b1;
        dior_n_o = 1'b1;
        diow_n_o = 1'b1;
        da_o = 3'h0;
        dd_o = 8'h5a;
    end
    // Strobe held four clocks or more for the two-stage pin sync
    task automatic cycle(input logic is_rd, input int hold);
        @(negedge core_clk_i);
        cs0_n_o = 1'b0;
        dior_n_o = ~is_rd;
        diow_n_o = is_rd;
        repeat (hold) @(negedge core_clk_i);
        cs0_n_o = 1'b1;
        dior_n_o = 1'b1;
        diow_n_o = 1'b1;
        // Released data lines must not keep the last value
        dd_o = ~dd_o;
        repeat (5) @(negedge core_clk_i);
    endtask
    task automatic rd(input logic [2:0] a, input int hold);
        da_o = a;
        cycle(1'b1, hold);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        da_o = a;
        dd_o = (a == ADDR_DRIVE_HEAD) ? (d | 8'ha0) : d;
        cycle(1'b0, 4);
    endtask
endmodule
`default_nettype wire

//--- verification/adhrs_top_tb_top.sv
// Self-checking bench for the drive/head and status register block
`timescale 1ns/1ps
`default_nettype none
module adhrs_top_tb_top
    import adhrs_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic cs0_n_i, dior_n_i, diow_n_i, dd_oe_o, intrq_o;
    logic [2:0] da_i;
    logic [7:0] dd_i, dd_o, cmd_code_o, d, e;
    logic hardware_reset_line_n_i = 1'b1, software_reset_bit_i = 1'b0;
    logic two_drive_cfg_i = 1'b0, drive_id_i = 1'b0, fault_i = 1'b0;
    logic spindle_ready_i = 1'b0, seek_start_i = 1'b0, seek_done_i = 1'b0;
    logic seek_fail_i = 1'b0, not_ready_i = 1'b0, sector_buf_req_i = 1'b0;
    logic cmd_done_i = 1'b0, cmd_error_i = 1'b0, track_cross_i = 1'b0;
    logic [HEAD_W-1:0] new_head_i = 4'h0, head_number_field_o;
    logic lba_mode_o, drive_select_o, selected_o, cmd_start_o, multi_abort_o;
    logic oe_q = 1'b0;
    logic [7:0] rd_q[$], cmd_q[$];
    int err_count = 0, checked = 0, seed = 69744;
    int aborts = 0;

    always #25 core_clk_i = ~core_clk_i;

    adhrs_top u_dut (
        .core_clk_i, .arst_n_i, .cs0_n_i, .dior_n_i, .diow_n_i, .da_i,
        .dd_i, .dd_o, .dd_oe_o, .intrq_o, .hardware_reset_line_n_i,
        .software_reset_bit_i, .two_drive_cfg_i, .drive_id_i,
        .spindle_ready_i, .seek_start_i, .seek_done_i, .seek_fail_i,
        .fault_i, .not_ready_i, .sector_buf_req_i, .cmd_done_i,
        .cmd_error_i, .track_cross_i, .new_head_i, .lba_mode_o,
        .head_number_field_o, .drive_select_o, .selected_o, .cmd_start_o,
        .cmd_code_o, .multi_abort_o
    );
    adhrs_host_model u_host (
        .core_clk_i, .cs0_n_o(cs0_n_i), .dior_n_o(dior_n_i),
        .diow_n_o(diow_n_i), .da_o(da_i), .dd_o(dd_i)
    );

    task automatic cmp(input string n, input logic [7:0] x, input logic [7:0] g);
        checked++;
        if (g !== x) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic stop_test;
        if (err_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] x);
        rd_q.push_back(x);
        u_host.rd(a, 4 + ($random(seed) & 3));
    endtask
    task automatic cmd(input logic [7:0] c, input logic ok);
        if (ok) cmd_q.push_back(c);
        u_host.wr(ADDR_STATUS, c);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge core_clk_i);
        s = 1'b0;
        repeat (3) @(negedge core_clk_i);
    endtask

    // Each answer that shows up takes the oldest note of its kind
    always @(negedge core_clk_i) begin
        if (dd_oe_o === 1'b1 && oe_q !== 1'b1) begin
            cmp("read", rd_q.size() > 0 ? rd_q.pop_front() : 8'hxx, dd_o);
        end
        if (cmd_start_o === 1'b1) begin
            cmp("cmd", cmd_q.size() > 0 ? cmd_q.pop_front() : 8'hxx, cmd_code_o);
        end
        if (multi_abort_o === 1'b1) begin
            aborts++;
        end
        oe_q <= dd_oe_o;
    end

    initial begin
        repeat (20000) @(posedge core_clk_i);
        err_count++;
        stop_test();
    end

    initial begin
        repeat (8) @(negedge core_clk_i);
        arst_n_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        // ------------------------------------------------------------
        // Busy after reset, then power-on flags
        // ------------------------------------------------------------
        rd(ADDR_STATUS, 8'h80);
        u_host.wr(ADDR_DRIVE_HEAD, 8'h0f);
        rd(ADDR_DRIVE_HEAD, READ_IDLE);
        pulse(cmd_done_i);
        cmp("intrq", 8'h01, {7'h00, intrq_o});
        rd(ADDR_STATUS, 8'h00);
        cmp("intrq", 8'h00, {7'h00, intrq_o});
        rd(ADDR_DRIVE_HEAD, DH_RESET);
        cmd(8'h20, 1'b0);
        rd(ADDR_STATUS, 8'h01);
        spindle_ready_i = 1'b1;
        rd(ADDR_STATUS, 8'h51);
        for (int i = 0; i < 4; i++) begin
            d = 8'($random(seed)) & 8'hef;
            e = d | 8'ha0;
            u_host.wr(ADDR_DRIVE_HEAD, d);
            cmp("dh", e, {1'b1, lba_mode_o, 1'b1, drive_select_o,
                head_number_field_o});
            rd(ADDR_DRIVE_HEAD, e);
        end
        // ------------------------------------------------------------
        // Media command, data request, track crossing, fault
        // ------------------------------------------------------------
        cmd(8'h20, 1'b1);
        rd(ADDR_STATUS, 8'h80);
        sector_buf_req_i = 1'b1;
        rd(ADDR_STATUS, 8'h58);
        new_head_i = 4'h9;
        pulse(track_cross_i);
        cmp("head", 8'h09, {4'h0, head_number_field_o});
        sector_buf_req_i = 1'b0;
        pulse(fault_i);
        rd(ADDR_STATUS, 8'h71);
        fault_i = 1'b1;
        cmd(8'h30, 1'b0);
        fault_i = 1'b0;
        rd(ADDR_STATUS, 8'h51);
        // Not-ready hold survives completion, seek flag follows the seek
        cmd(8'h20, 1'b1);
        pulse(not_ready_i);
        pulse(cmd_done_i);
        rd(ADDR_STATUS, 8'h11);
        cmd(8'h70, 1'b1);
        pulse(seek_start_i);
        pulse(seek_done_i);
        pulse(cmd_error_i);
        pulse(cmd_done_i);
        rd(ADDR_STATUS, 8'h51);
        cmd(8'h70, 1'b1);
        pulse(seek_start_i);
        pulse(seek_fail_i);
        rd(ADDR_STATUS, 8'h01);
        // ------------------------------------------------------------
        // Drive selection, then both reset sources
        // ------------------------------------------------------------
        two_drive_cfg_i = 1'b1;
        u_host.wr(ADDR_DRIVE_HEAD, 8'h10);
        cmp("selected", 8'h00, {7'h00, selected_o});
        u_host.rd(ADDR_STATUS, 5);
        cmd(8'h90, 1'b0);
        two_drive_cfg_i = 1'b0;
        rd(ADDR_STATUS, STATUS_UNSEL);
        u_host.wr(ADDR_DRIVE_HEAD, 8'h00);
        hardware_reset_line_n_i = 1'b0;
        repeat (6) @(negedge core_clk_i);
        hardware_reset_line_n_i = 1'b1;
        rd(ADDR_STATUS, 8'h80);
        pulse(cmd_done_i);
        software_reset_bit_i = 1'b1;
        repeat (3) @(negedge core_clk_i);
        software_reset_bit_i = 1'b0;
        rd(ADDR_STATUS, 8'h80);
        cmp("notes left", 8'h00, 8'(rd_q.size() + cmd_q.size()));
        cmp("aborts", 8'h05, 8'(aborts));
        stop_test();
    end
endmodule
`default_nettype wire
